// ### hw/tmc_timer.sv
// Overview of operation
// - at limit restart from zero, set overflow
// - half-written limit suppresses overflow flag
// - reset clears limit: free-running counter
// - no clock: limit loads on second byte
// - clocked: load at limit-1 to limit step
// - main control write resets byte latches
// - halt mode freezes latch state
// - halt mode writes limit directly
// - capture edge sets channel flag
// - counter match sets flag in compare/pwm
// - no flag at 0% or 100% pwm
// - interrupt when flag and enable set
// - read-then-write-zero clears flag
// - reset clears flag and enable
// - mode b selects pwm, a capture/compare
// - edge field 00 releases the pin
// - capture edges rising, falling, both
// - compare toggles, clears or sets pin
// - edge pwm polarity by edge field
// - center pwm polarity on up-compare
// - clock select field picks counter clock
// - center select makes up/down counting
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  input wire tmc_pkg::tmc_apb_req_t APB_REQ_IN,
  output tmc_pkg::tmc_apb_rsp_t APB_RSP_OUT,
  input wire logic DEBUG_HALT_IN,
  input wire logic FIXED_TICK_IN,
  input wire logic EXT_CLK_IN,
  input wire logic CH_PIN_IN,
  output logic CH_PIN_OUT,
  output logic CH_PIN_OE_OUT,
  output logic CH_IRQ_OUT,
  output logic OVF_IRQ_OUT
);
  import tmc_pkg::*;

  logic [15:0] cnt_r, limit_r, lbuf_r, chval_r;
  logic [1:0] clks_r, els_r;
  logic center_r, ovf_r, ovf_ie_r, ovf_armed_r;
  logic got_high_r, got_low_r;
  logic flag_r, ie_r, mode_b_r, mode_a_r, flag_seen_r;
  logic down_r, pin_r;
  logic [31:0] rdata_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r, fix_s1_r, fix_s2_r;
  logic pin_s1_r, pin_s2_r, pin_s3_r;

  wire wr = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite;
  wire rd = APB_REQ_IN.psel && APB_REQ_IN.penable && !APB_REQ_IN.pwrite;
  wire [11:0] a = APB_REQ_IN.paddr;
  wire [7:0] wd = APB_REQ_IN.pwdata[7:0];
  wire wr_main = wr && a == ADDR_MAIN_CTRL;
  wire wr_cnt = wr && a == ADDR_COUNTER;
  wire wr_hi = wr && a == ADDR_LIMIT_HIGH;
  wire wr_lo = wr && a == ADDR_LIMIT_LOW;
  wire wr_cc = wr && a == ADDR_CH_CTRL;
  wire wr_cv = wr && a == ADDR_CH_VALUE;
  wire rd_main = rd && a == ADDR_MAIN_CTRL;
  wire rd_cc = rd && a == ADDR_CH_CTRL;
  wire mapped = a == ADDR_MAIN_CTRL || a == ADDR_COUNTER || a == ADDR_LIMIT_HIGH
    || a == ADDR_LIMIT_LOW || a == ADDR_CH_CTRL || a == ADDR_CH_VALUE;
  wire halt = DEBUG_HALT_IN;

  // counter tick from the selected source
  wire ext_rise = ext_s2_r && !ext_s3_r;
  wire tick_src = (clks_r == CLKS_BUS) ? 1'b1 :
                  (clks_r == CLKS_FIXED) ? fix_s2_r :
                  (clks_r == CLKS_EXT) ? ext_rise : 1'b0;
  wire tick = tick_src && !halt;
  wire free_run = limit_r == CNT_ZERO;
  wire [15:0] top = free_run ? CNT_FREE_TOP : limit_r;
  wire at_top = cnt_r == top;
  wire up_wrap = !center_r && at_top;
  wire cpwm_bottom = center_r && down_r && cnt_r == CNT_ONE;
  wire wrap_evt = tick && (up_wrap || cpwm_bottom);
  wire [15:0] pre_top = top - CNT_ONE;
  wire both_written = got_high_r && got_low_r;
  wire load_clocked = tick && both_written && cnt_r == pre_top && !center_r;
  wire load_center = tick && both_written && center_r && !down_r && cnt_r == pre_top;

  function automatic tmc_chmode_t ch_mode(input logic c, input logic b, input logic ma,
                                          input logic [1:0] e);
    if (e == ELS_OFF)
      ch_mode = CH_GPIO;
    else if (c)
      ch_mode = CH_CPWM;
    else if (b)
      ch_mode = CH_EPWM;
    else if (ma)
      ch_mode = CH_COMPARE;
    else
      ch_mode = CH_CAPTURE;
  endfunction

  tmc_chmode_t mode;
  assign mode = ch_mode(center_r, mode_b_r, mode_a_r, els_r);

  wire pin_rise = pin_s2_r && !pin_s3_r;
  wire pin_fall = !pin_s2_r && pin_s3_r;
  wire cap_evt = mode == CH_CAPTURE && ((els_r[0] && pin_rise) || (els_r[1] && pin_fall));
  wire pwm_mode = mode == CH_EPWM || mode == CH_CPWM;
  wire duty_edge = chval_r == CNT_ZERO || chval_r > top;
  wire match = tick && cnt_r == chval_r;
  wire cmp_evt = match && (mode == CH_COMPARE || (pwm_mode && !duty_edge));
  wire ch_evt = cap_evt || cmp_evt;
  wire ovf_evt = wrap_evt && !(got_high_r ^ got_low_r);

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      {ext_s1_r, ext_s2_r, ext_s3_r, fix_s1_r, fix_s2_r} <= 5'h00;
      {pin_s1_r, pin_s2_r, pin_s3_r} <= 3'h0;
    end
    else if (CLK_EN_IN)
    begin
      ext_s1_r <= EXT_CLK_IN;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      fix_s1_r <= FIXED_TICK_IN;
      fix_s2_r <= fix_s1_r;
      pin_s1_r <= CH_PIN_IN;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // main control, counter and overflow
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      cnt_r <= CNT_ZERO;
      down_r <= 1'b0;
      clks_r <= CLKS_NONE;
      center_r <= 1'b0;
      ovf_r <= 1'b0;
      ovf_ie_r <= 1'b0;
      ovf_armed_r <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (wr_cnt)
      begin
        cnt_r <= CNT_ZERO;
        down_r <= 1'b0;
      end
      else if (tick)
      begin
        if (up_wrap)
          cnt_r <= CNT_ZERO;
        else if (center_r && !down_r && at_top)
        begin
          down_r <= 1'b1;
          cnt_r <= cnt_r - CNT_ONE;
        end
        else if (center_r && down_r && cnt_r == CNT_ZERO)
        begin
          down_r <= 1'b0;
          cnt_r <= cnt_r + CNT_ONE;
        end
        else if (down_r)
          cnt_r <= cnt_r - CNT_ONE;
        else
          cnt_r <= cnt_r + CNT_ONE;
      end
      if (rd_main && ovf_r)
        ovf_armed_r <= 1'b1;
      if (wr_main)
      begin
        clks_r <= wd[MC_CLKS_LSB +: 2];
        center_r <= wd[MC_CENTER_BIT];
        ovf_ie_r <= wd[MC_OVF_BIT - 1];
      end
      if (ovf_evt)
      begin
        ovf_r <= 1'b1;
        ovf_armed_r <= 1'b0;
      end
      else if (wr_main && !wd[MC_OVF_BIT] && ovf_armed_r)
      begin
        ovf_r <= 1'b0;
        ovf_armed_r <= 1'b0;
      end
    end
  end

  // limit register with byte-wise coherency
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      limit_r <= LIMIT_RESET;
      lbuf_r <= LIMIT_RESET;
      got_high_r <= 1'b0;
      got_low_r <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (wr_main)
      begin
        got_high_r <= 1'b0;
        got_low_r <= 1'b0;
      end
      else if (halt)
      begin
        if (wr_hi)
          limit_r[15:8] <= wd;
        if (wr_lo)
          limit_r[7:0] <= wd;
      end
      else if (wr_hi || wr_lo)
      begin
        if (wr_hi)
          lbuf_r[15:8] <= wd;
        if (wr_lo)
          lbuf_r[7:0] <= wd;
        if (clks_r == CLKS_NONE && (wr_hi ? got_low_r : got_high_r))
        begin
          limit_r <= wr_hi ? {wd, lbuf_r[7:0]} : {lbuf_r[15:8], wd};
          got_high_r <= 1'b0;
          got_low_r <= 1'b0;
        end
        else
        begin
          got_high_r <= got_high_r | wr_hi;
          got_low_r <= got_low_r | wr_lo;
        end
      end
      else if (load_clocked || load_center)
      begin
        limit_r <= lbuf_r;
        got_high_r <= 1'b0;
        got_low_r <= 1'b0;
      end
    end
  end

  // channel control/status and flag clearing
  wire flag_clr = wr_cc && !wd[CC_FLAG_BIT] && flag_seen_r;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      mode_b_r <= 1'b0;
      mode_a_r <= 1'b0;
      els_r <= ELS_OFF;
      flag_seen_r <= 1'b0;
      chval_r <= CNT_ZERO;
    end
    else if (CLK_EN_IN)
    begin
      if (wr_cc)
      begin
        ie_r <= wd[CC_IE_BIT];
        mode_b_r <= wd[CC_MODE_B_BIT];
        mode_a_r <= wd[CC_MODE_A_BIT];
        els_r <= wd[CC_ELS_LSB +: 2];
      end
      if (wr_cv && mode != CH_CAPTURE)
        chval_r <= APB_REQ_IN.pwdata[15:0];
      else if (cap_evt)
        chval_r <= cnt_r;
      if (ch_evt)
      begin
        flag_r <= 1'b1;
        flag_seen_r <= 1'b0;
      end
      else if (flag_clr)
      begin
        flag_r <= 1'b0;
        flag_seen_r <= 1'b0;
      end
      else if (rd_cc && flag_r)
        flag_seen_r <= 1'b1;
    end
  end

  // pin drive per mode
  wire cmp_up = match && !(center_r && down_r);
  logic pin_nxt;
  always_comb
  begin
    pin_nxt = pin_r;
    unique case (mode)
      CH_GPIO, CH_CAPTURE: pin_nxt = pin_r;
      CH_COMPARE:
        if (match)
          pin_nxt = (els_r == ELS_01) ? !pin_r : (els_r == ELS_11);
      CH_EPWM:
        if (chval_r == CNT_ZERO)
          pin_nxt = els_r[0];
        else if (match)
          pin_nxt = els_r[0];
        else if (tick && up_wrap)
          pin_nxt = !els_r[0];
      CH_CPWM:
        if (cmp_up)
          pin_nxt = els_r[0];
        else if (match)
          pin_nxt = !els_r[0];
    endcase
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      pin_r <= 1'b0;
    else if (CLK_EN_IN)
      pin_r <= pin_nxt;
  end

  wire [7:0] main_rd = {ovf_r, ovf_ie_r, center_r, clks_r, 3'h0};
  wire [7:0] cc_rd = {flag_r, ie_r, mode_b_r, mode_a_r, els_r, 2'h0};
  wire [31:0] rd_mux =
    (a == ADDR_MAIN_CTRL) ? {24'h000000, main_rd} :
    (a == ADDR_COUNTER) ? {16'h0000, cnt_r} :
    (a == ADDR_LIMIT_HIGH) ? {24'h000000, limit_r[15:8]} :
    (a == ADDR_LIMIT_LOW) ? {24'h000000, limit_r[7:0]} :
    (a == ADDR_CH_CTRL) ? {24'h000000, cc_rd} :
    (a == ADDR_CH_VALUE) ? {16'h0000, chval_r} : 32'h00000000;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
      rdata_r <= 32'h00000000;
    else if (CLK_EN_IN && APB_REQ_IN.psel && !APB_REQ_IN.penable)
      rdata_r <= rd_mux;
  end

  assign APB_RSP_OUT.prdata = rdata_r;
  assign APB_RSP_OUT.pready = 1'b1;
  assign APB_RSP_OUT.pslverr = APB_REQ_IN.psel && APB_REQ_IN.penable && !mapped;
  assign CH_PIN_OUT = pin_r;
  assign CH_PIN_OE_OUT = mode == CH_COMPARE || pwm_mode;
  assign CH_IRQ_OUT = flag_r && ie_r;
  assign OVF_IRQ_OUT = ovf_r && ovf_ie_r;

  AST_FLAG_SET: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CLK_EN_IN && ch_evt |=> flag_r) else $error("event did not set flag");
  AST_IRQ: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CLK_EN_IN && ch_evt && ie_r && !wr_cc |=> CH_IRQ_OUT) else $error("irq mismatch");
  AST_CLR_NEEDS_READ: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    flag_r && !flag_seen_r && !ch_evt |=> flag_r) else $error("flag cleared without read");
  AST_WRAP: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CLK_EN_IN && tick && up_wrap && !wr_cnt |=> cnt_r == CNT_ZERO) else $error("no wrap");
  AST_NO_OVF_HALF: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !ovf_r && (got_high_r ^ got_low_r) |=> !ovf_r) else $error("overflow while half written");
  AST_MAIN_RESETS: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CLK_EN_IN && wr_main |=> !got_high_r && !got_low_r) else $error("latch not reset");
  AST_HALT_DIRECT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CLK_EN_IN && halt && wr_lo && !wr_main |=> limit_r[7:0] == $past(wd))
    else $error("halt write not direct");
  AST_GPIO_RELEASE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    els_r == ELS_OFF |-> !CH_PIN_OE_OUT) else $error("pin driven while released");
  AST_PWM_EDGE_DUTY: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    pwm_mode && duty_edge && !cap_evt |-> !ch_evt) else $error("flag at edge duty");
  COV_CAPTURE: cover property (@(posedge CLK_SYS_IN) cap_evt);
  COV_OVF: cover property (@(posedge CLK_SYS_IN) ovf_evt);
  COV_LOAD: cover property (@(posedge CLK_SYS_IN) load_clocked);
  COV_CLEAR: cover property (@(posedge CLK_SYS_IN) flag_clr);
endmodule
`default_nettype wire

// ### hw/tmc_pkg.sv
package tmc_pkg;
  localparam int unsigned CLK_SYS_HZ = 10000000;
  localparam int unsigned IN_STABLE_CYCLES = 2;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FREE_PRE = 16'hfffe;
  localparam logic [15:0] CNT_FREE_TOP = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [11:0] ADDR_MAIN_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNTER = 12'h004;
  localparam logic [11:0] ADDR_LIMIT_HIGH = 12'h008;
  localparam logic [11:0] ADDR_LIMIT_LOW = 12'h00c;
  localparam logic [11:0] ADDR_CH_CTRL = 12'h010;
  localparam logic [11:0] ADDR_CH_VALUE = 12'h014;
  localparam int unsigned MC_OVF_BIT = 7;
  localparam int unsigned MC_CENTER_BIT = 5;
  localparam int unsigned MC_CLKS_LSB = 3;
  localparam int unsigned CC_FLAG_BIT = 7;
  localparam int unsigned CC_IE_BIT = 6;
  localparam int unsigned CC_MODE_B_BIT = 5;
  localparam int unsigned CC_MODE_A_BIT = 4;
  localparam int unsigned CC_ELS_LSB = 2;
  localparam logic [1:0] CLKS_NONE = 2'h0;
  localparam logic [1:0] CLKS_BUS = 2'h1;
  localparam logic [1:0] CLKS_FIXED = 2'h2;
  localparam logic [1:0] CLKS_EXT = 2'h3;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_01 = 2'h1;
  localparam logic [1:0] ELS_10 = 2'h2;
  localparam logic [1:0] ELS_11 = 2'h3;
  typedef enum logic [4:0] {
    CH_GPIO = 5'b00001,
    CH_CAPTURE = 5'b00010,
    CH_COMPARE = 5'b00100,
    CH_EPWM = 5'b01000,
    CH_CPWM = 5'b10000
  } tmc_chmode_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tmc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmc_apb_rsp_t;
endpackage

// ### tb/tmc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  input wire logic drv_in,
  input wire logic oe_in,
  output logic pin_out,
  output logic tick_out,
  output logic ext_out
);
  logic [2:0] div_r;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end
  // external clock at bus rate / 8, inside the bus/4 limit; fixed tick every other cycle
  assign ext_out = div_r[2];
  assign tick_out = div_r[0];
  // timer drive wins while enabled, otherwise the outside source sets the level
  assign pin_out = oe_in ? drv_in : level_in;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic halt = 1'b0;
  logic lvl = 1'b0;
  tmc_apb_req_t req = '0;
  tmc_apb_rsp_t rsp;
  wire logic tick;
  wire logic ext;
  wire logic pin_in;
  logic pin_drv;
  logic pin_oe;
  logic ch_irq;
  logic ovf_irq;
  logic [31:0] rd;
  int err_count = 0;
  int num_checks = 0;

  initial forever #50 clk = ~clk;

  tmc_timer tmc_timer_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1),
    .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .DEBUG_HALT_IN(halt), .FIXED_TICK_IN(tick),
    .EXT_CLK_IN(ext), .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_drv), .CH_PIN_OE_OUT(pin_oe),
    .CH_IRQ_OUT(ch_irq), .OVF_IRQ_OUT(ovf_irq));

  tmc_pin_model tmc_pin_model_inst (.clk_in(clk), .rst_in(rst), .level_in(lvl),
    .drv_in(pin_drv), .oe_in(pin_oe), .pin_out(pin_in), .tick_out(tick), .ext_out(ext));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {16'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      err_count++;
      stop_test();
    end
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0);
    check(rd, exp);
  endtask

  // polls until the masked value appears, bounded
  task automatic pl(input logic [11:0] a, input logic [15:0] m, input logic [15:0] v);
    int i;
    apb(1'b0, a, 16'h0);
    for (i = 0; i < 60 && (rd[15:0] & m) !== v; i++)
      apb(1'b0, a, 16'h0);
    check(rd[15:0] & m, v);
    if ((rd[15:0] & m) !== v)
      stop_test();
  endtask

  // stop the counter first, so no new overflow restarts the flag clearing sequence
  task automatic stopc();
    wr(ADDR_MAIN_CTRL, 16'h0);
    apb(1'b0, ADDR_MAIN_CTRL, 16'h0);
    wr(ADDR_MAIN_CTRL, 16'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(ADDR_LIMIT_HIGH, 32'h0);
    rc(ADDR_LIMIT_LOW, 32'h0);
    rc(ADDR_CH_CTRL, 32'h0);
    check({ch_irq, ovf_irq, pin_oe}, 32'h0);
    $display("reset test done");
    wr(ADDR_LIMIT_HIGH, 16'h0);
    wr(ADDR_LIMIT_LOW, 16'h6);
    rc(ADDR_LIMIT_LOW, 32'h6);
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_COUNTER, 16'h0);
      wr(ADDR_MAIN_CTRL, 16'(c << 3) | 16'h40);
      pl(ADDR_MAIN_CTRL, 16'h80, 16'h80);
      check(ovf_irq, 1'b1);
      pl(ADDR_COUNTER, 16'hffff, 16'h0);
      stopc();
      apb(1'b0, ADDR_COUNTER, 16'h0);
      check(rd[15:0] <= 16'h6, 1'b1);
    end
    wr(ADDR_COUNTER, 16'h0);
    repeat (20) @(posedge clk);
    rc(ADDR_COUNTER, 32'h0);
    rc(ADDR_MAIN_CTRL, 32'h0);
    $display("clock source test done");
    wr(ADDR_MAIN_CTRL, 16'h8);
    wr(ADDR_LIMIT_HIGH, 16'h0);
    repeat (40) @(posedge clk);
    rc(ADDR_MAIN_CTRL, 32'h8);
    wr(ADDR_LIMIT_LOW, 16'ha);
    pl(ADDR_COUNTER, 16'hffff, 16'ha);
    pl(ADDR_MAIN_CTRL, 16'h80, 16'h80);
    stopc();
    wr(ADDR_LIMIT_HIGH, 16'h0);
    wr(ADDR_MAIN_CTRL, 16'h8);
    wr(ADDR_LIMIT_LOW, 16'hc);
    repeat (40) @(posedge clk);
    rc(ADDR_MAIN_CTRL, 32'h8);
    halt <= 1'b1;
    wr(ADDR_LIMIT_LOW, 16'h4);
    wr(ADDR_LIMIT_HIGH, 16'h0);
    rc(ADDR_LIMIT_LOW, 32'h4);
    wr(ADDR_COUNTER, 16'h0);
    halt <= 1'b0;
    repeat (40) @(posedge clk);
    rc(ADDR_MAIN_CTRL, 32'h8);
    wr(ADDR_LIMIT_HIGH, 16'h0);
    pl(ADDR_MAIN_CTRL, 16'h80, 16'h80);
    stopc();
    $display("limit buffer test done");
    wr(ADDR_LIMIT_HIGH, 16'h0);
    wr(ADDR_LIMIT_LOW, 16'hf);
    wr(ADDR_CH_VALUE, 16'h3);
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_CH_CTRL, 16'h50 | 16'((3 - k) << 2));
      @(negedge clk);
      check(pin_oe, 1'b1);
      wr(ADDR_COUNTER, 16'h0);
      wr(ADDR_MAIN_CTRL, 16'h8);
      pl(ADDR_CH_CTRL, 16'h80, 16'h80);
      check(ch_irq, 1'b1);
      stopc();
      check(pin_drv, k != 1);
    end
    wr(ADDR_CH_CTRL, 16'h54);
    rc(ADDR_CH_CTRL, 32'h54);
    check(ch_irq, 1'b0);
    wr(ADDR_MAIN_CTRL, 16'h8);
    repeat (40) @(posedge clk);
    stopc();
    wr(ADDR_CH_CTRL, 16'h54);
    rc(ADDR_CH_CTRL, 32'hd4);
    wr(ADDR_CH_CTRL, 16'hd4);
    rc(ADDR_CH_CTRL, 32'hd4);
    wr(ADDR_CH_VALUE, 16'h0);
    wr(ADDR_CH_CTRL, 16'h28);
    wr(ADDR_COUNTER, 16'h0);
    wr(ADDR_MAIN_CTRL, 16'h8);
    repeat (40) @(posedge clk);
    stopc();
    rc(ADDR_CH_CTRL, 32'h28);
    wr(ADDR_CH_VALUE, 16'h3);
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_CH_CTRL, 16'h20 | 16'((m[0] ? 1 : 2) << 2));
      wr(ADDR_COUNTER, 16'h0);
      wr(ADDR_MAIN_CTRL, m[1] ? 16'h28 : 16'h8);
      pl(ADDR_CH_CTRL, 16'h80, 16'h80);
      stopc();
      check(pin_drv, m[0]);
    end
    $display("compare and pwm test done");
    wr(ADDR_CH_CTRL, 16'h30);
    @(negedge clk);
    check(pin_oe, 1'b0);
    wr(ADDR_MAIN_CTRL, 16'h8);
    for (int e = 1; e < 4; e++)
    begin
      lvl <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, ADDR_CH_CTRL, 16'h0);
      wr(ADDR_CH_CTRL, 16'(e << 2));
      lvl <= 1'b1;
      repeat (6) @(posedge clk);
      rc(ADDR_CH_CTRL, {e[0], 7'(e << 2)});
      wr(ADDR_CH_CTRL, 16'(e << 2));
      lvl <= 1'b0;
      repeat (6) @(posedge clk);
      rc(ADDR_CH_CTRL, {e[1], 7'(e << 2)});
    end
    $display("capture test done");
    stop_test();
  end
endmodule
`default_nettype wire
